/* File: logic/bam_top.sv */
// Buffer address mapper: download, upload and chip-side address paths
// Notes on behaviour
// [R1] Abort programming on supply deviation beyond 15%
// [R2] Negative external supply is never checked
// [R3] Record address is page byte plus offset
// [R4] Auto mode captures first record page
// [R5] Reset leaves file offset in auto mode
// [R6] Download page is record page minus offset
// [R7] Drop bytes whose page lies beyond 1F
// [R8] Partly stored record is not counted
// [R9] Upload adds file offset to page
// [R10] Upload in auto mode uses offset zero
// [R11] Chip page plus buffer offset, low kept
// [R12] Same translation for read, compare, program
// [R13] Buffer holds 8K bytes
// [R14] Invert data to and from chip
// [R15] Confirm before programming, then verify
// [R16] Report match, or each difference
// [R17] Buffer page wraps within buffer range
`timescale 1ns/1ps
module bam_top
  import bam_pkg::*;
#(
  parameter int unsigned FIFO_W = bam_pkg::FIFO_WIDTH,
  parameter int unsigned FIFO_D = bam_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  // Configuration commands
  input  wire logic                 i_file_offset_command,
  input  wire logic                 i_file_offset_auto,
  input  wire logic [7:0]           i_file_offset,
  input  wire logic                 i_buffer_offset_command,
  input  wire logic [7:0]           i_buffer_offset,
  input  wire logic                 i_invert_data_command,
  input  wire logic                 i_invert_data,
  // Download stream: record bytes
  input  wire logic                 i_dl_valid,
  input  wire logic                 i_dl_first,
  input  wire logic                 i_dl_last,
  input  wire logic [15:0]          i_dl_addr,
  input  wire logic [7:0]           i_dl_data,
  output logic                      o_dl_ready,
  output logic [15:0]               o_dl_loaded_cnt,
  // Upload address request
  input  wire logic                 i_ul_valid,
  input  wire logic [bam_pkg::ADDR_BITS-1:0] i_ul_addr,
  output logic                      o_ul_valid,
  output logic [15:0]               o_ul_addr,
  output logic [7:0]                o_ul_data,
  // Chip operation
  input  wire logic                 i_op_start,
  input  wire bam_pkg::bam_op_t     i_op_kind,
  input  wire logic [15:0]          i_chip_addr,
  input  wire logic [7:0]           i_chip_rdata,
  output logic [7:0]                o_chip_wdata,
  output logic                      o_chip_we,
  input  wire logic                 i_chip_step_done,
  input  wire logic                 i_op_last,
  output logic [bam_pkg::ADDR_BITS-1:0] o_buf_addr,
  // Operator confirmation
  output logic                      o_confirm_req,
  input  wire logic                 i_confirm_valid,
  input  wire logic                 i_confirm_yes,
  // Compare results
  output logic                      o_diff_valid,
  output logic [15:0]               o_diff_addr,
  output logic                      o_match,
  output logic                      o_busy,
  // Supply monitor
  input  wire logic [9:0]           i_vpp_meas,
  input  wire logic [9:0]           i_vpp_expect,
  output logic                      o_abort
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic                 auto_mode;
    logic                 got_first;
    logic [7:0]           fofs;
    logic [7:0]           bofs;
    logic                 inv;
    logic                 rec_bad;
    logic [15:0]          loaded;
    logic                 ul_valid;
    logic [15:0]          ul_addr;
    logic [7:0]           ul_data;
    bam_state_t           state;
    bam_op_t              op;
    logic                 any_diff;
    logic                 confirm;
    logic                 diff_valid;
    logic [15:0]          diff_addr;
    logic                 match;
    logic                 abort;
    logic [7:0]           wdata;
    logic                 we;
    logic [ADDR_BITS-1:0] baddr;
    logic                 busy;
  } bam_st_t;

  bam_st_t    st_r;
  bam_st_t    st_nxt;
  logic [7:0] buf_mem_r [BUF_BYTES];
  logic       f_valid;
  logic       f_ready;
  logic [FIFO_W-1:0] f_data;
  logic [7:0] f_page;
  logic [7:0] dl_page;
  logic [7:0] chip_page;
  logic [ADDR_BITS-1:0] chip_baddr;
  logic [7:0] buf_rd;
  logic [7:0] chip_in;
  logic [10:0] vpp_dev;
  logic [16:0] vpp_lim;
  logic        vpp_bad;
  logic        wr_en;
  logic        rec_bad_in;

  // ****************************************
  // Download FIFO
  // ****************************************
  // Back-pressure reaches the serial parser through o_dl_ready
  bam_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_in_valid  (i_dl_valid),
    .i_in_data   ({i_dl_addr, i_dl_data}),
    .o_in_ready  (o_dl_ready),
    .o_out_valid (f_valid),
    .o_out_data  (f_data),
    .i_out_ready (f_ready)
  );
  // Flags travel beside the FIFO; parser holds them with the byte
  assign f_ready = 1'b1;
  assign f_page  = f_data[23:16];

  // ****************************************
  // Address arithmetic
  // ****************************************
  // [R3] [R4] [R6] page minus offset
  assign dl_page = (st_r.auto_mode && !st_r.got_first) ? 8'h00
                 : f_page - st_r.fofs;
  // [R11] [R12] [R17] page plus buffer offset, wrapped
  assign chip_page  = i_chip_addr[15:8] + st_r.bofs;
  assign chip_baddr = {chip_page[PAGE_BITS-1:0], i_chip_addr[7:0]};
  // [R14] inversion on the chip side
  assign chip_in = st_r.inv ? ~i_chip_rdata : i_chip_rdata;
  assign buf_rd  = buf_mem_r[chip_baddr];
  // [R1] [R2] only the internal supply is measured
  assign vpp_dev = (i_vpp_meas > i_vpp_expect)
                 ? 11'(i_vpp_meas - i_vpp_expect)
                 : 11'(i_vpp_expect - i_vpp_meas);
  assign vpp_lim = 17'(i_vpp_expect) * 17'(TOL_PCT);
  assign vpp_bad = (17'(vpp_dev) * 17'(TOL_DIV)) > vpp_lim;
  // [R7] [R13] keep only pages 00 to 1F
  assign wr_en = f_valid && (dl_page <= PAGE_LAST);
  // [R8] first byte starts a fresh record
  assign rec_bad_in = st_r.rec_bad && !i_dl_first;

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    st_nxt            = st_r;
    st_nxt.ul_valid   = 1'b0;
    st_nxt.diff_valid = 1'b0;
    st_nxt.we         = 1'b0;
    // Configuration
    if (i_file_offset_command)
    begin
      st_nxt.auto_mode = i_file_offset_auto;
      st_nxt.fofs      = i_file_offset;
      st_nxt.got_first = 1'b0;
    end
    if (i_buffer_offset_command)
    begin
      st_nxt.bofs = i_buffer_offset;
    end
    if (i_invert_data_command)
    begin
      st_nxt.inv = i_invert_data;
    end
    // [R4] capture first page in auto mode
    if (f_valid && st_r.auto_mode && !st_r.got_first)
    begin
      st_nxt.fofs      = f_page;
      st_nxt.got_first = 1'b1;
    end
    // [R8] a dropped byte spoils the record count
    if (f_valid)
    begin
      st_nxt.rec_bad = rec_bad_in || !wr_en;
      if (i_dl_last)
      begin
        st_nxt.rec_bad = 1'b0;
        if (wr_en && !rec_bad_in)
        begin
          st_nxt.loaded = st_r.loaded + 16'h0001;
        end
      end
    end
    // [R9] [R10] upload page plus offset, zero in auto
    if (i_ul_valid)
    begin
      st_nxt.ul_valid = 1'b1;
      st_nxt.ul_data  = buf_mem_r[i_ul_addr];
      st_nxt.ul_addr  = {8'({3'b000, i_ul_addr[12:8]})
                        + (st_r.auto_mode ? 8'h00 : st_r.fofs),
                        i_ul_addr[7:0]};
    end
    // Chip operation sequencer
    st_nxt.baddr = chip_baddr;
    case (st_r.state)
      BAM_ST_IDLE:
      begin
        if (i_op_start)
        begin
          st_nxt.op       = i_op_kind;
          st_nxt.any_diff = 1'b0;
          st_nxt.match    = 1'b0;
          st_nxt.abort    = 1'b0;
          // [R15] ask first for programming
          if (i_op_kind == BAM_OP_PROGRAM)
          begin
            st_nxt.confirm = 1'b1;
            st_nxt.state   = BAM_ST_ASK;
          end
          else
          begin
            st_nxt.state = (i_op_kind == BAM_OP_COMPARE)
                         ? BAM_ST_VERIFY : BAM_ST_PROG;
          end
        end
      end
      BAM_ST_ASK:
      begin
        // [R15] proceed only on yes
        if (i_confirm_valid)
        begin
          st_nxt.confirm = 1'b0;
          st_nxt.state   = i_confirm_yes ? BAM_ST_PROG : BAM_ST_IDLE;
        end
      end
      BAM_ST_PROG:
      begin
        if (st_r.op == BAM_OP_PROGRAM)
        begin
          // [R14] complement on write
          st_nxt.wdata = st_r.inv ? ~buf_rd : buf_rd;
          st_nxt.we    = 1'b1;
          // [R1] abort on supply deviation
          if (vpp_bad)
          begin
            st_nxt.abort = 1'b1;
            st_nxt.we    = 1'b0;
            st_nxt.state = BAM_ST_DONE;
          end
          else if (i_chip_step_done && i_op_last)
          begin
            st_nxt.state = BAM_ST_VERIFY;
          end
        end
        else if (i_chip_step_done && i_op_last)
        begin
          st_nxt.state = BAM_ST_DONE;
        end
      end
      BAM_ST_VERIFY:
      begin
        // [R16] each difference reported
        if (i_chip_step_done && (chip_in != buf_rd))
        begin
          st_nxt.diff_valid = 1'b1;
          st_nxt.diff_addr  = i_chip_addr;
          st_nxt.any_diff   = 1'b1;
        end
        if (i_chip_step_done && i_op_last)
        begin
          st_nxt.match = !(st_nxt.any_diff);
          st_nxt.state = BAM_ST_DONE;
        end
      end
      BAM_ST_DONE:
      begin
        st_nxt.state = BAM_ST_IDLE;
      end
      default:
      begin
        st_nxt.state = BAM_ST_IDLE;
      end
    endcase
    st_nxt.busy = (st_nxt.state != BAM_ST_IDLE);
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      st_r           <= '0;
      // [R5] auto offset after reset
      st_r.auto_mode <= AUTO_RST;
      st_r.fofs      <= FOFS_RST;
      st_r.bofs      <= BOFS_RST;
      st_r.inv       <= INV_RST;
      st_r.state     <= BAM_ST_IDLE;
      st_r.op        <= BAM_OP_READ;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Buffer storage kept out of the state struct; no reset on data
  always_ff @(posedge i_clk)
  begin
    if (wr_en)
    begin
      buf_mem_r[{dl_page[PAGE_BITS-1:0], f_data[15:8]}] <= f_data[7:0];
    end
    else if (st_r.state == BAM_ST_PROG && st_r.op == BAM_OP_READ
             && i_chip_step_done)
    begin
      // [R12] [R14] chip read into buffer
      buf_mem_r[chip_baddr] <= chip_in;
    end
  end

  assign o_dl_loaded_cnt = st_r.loaded;
  assign o_ul_valid      = st_r.ul_valid;
  assign o_ul_addr       = st_r.ul_addr;
  assign o_ul_data       = st_r.ul_data;
  assign o_chip_wdata    = st_r.wdata;
  assign o_chip_we       = st_r.we;
  assign o_buf_addr      = st_r.baddr;
  assign o_confirm_req   = st_r.confirm;
  assign o_diff_valid    = st_r.diff_valid;
  assign o_diff_addr     = st_r.diff_addr;
  assign o_match         = st_r.match;
  assign o_abort         = st_r.abort;
  assign o_busy          = st_r.busy;

  // ****************************************
  // Assertions
  // ****************************************
  abort_on_vpp_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R1]
    st_r.state == BAM_ST_PROG && st_r.op == BAM_OP_PROGRAM && vpp_bad
    |=> o_abort && st_r.state == BAM_ST_DONE)
    else $error("supply deviation did not abort");
  confirm_gate_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R15]
    st_r.state == BAM_ST_ASK && i_confirm_valid && !i_confirm_yes
    |=> st_r.state == BAM_ST_IDLE && !o_chip_we)
    else $error("programming without yes");
  ul_offset_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R9]
    i_ul_valid && !st_r.auto_mode && !i_file_offset_command
    |=> o_ul_addr[15:8] == $past(st_r.fofs) + 8'($past(i_ul_addr[12:8])))
    else $error("upload page missing offset");
  ul_auto_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R10]
    i_ul_valid && st_r.auto_mode
    |=> o_ul_addr[15:8] == 8'($past(i_ul_addr[12:8])))
    else $error("auto upload not zero offset");
  chip_map_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R11]
    1'b1 |=> o_buf_addr[7:0] == $past(i_chip_addr[7:0])
      && o_buf_addr[12:8] == 5'($past(i_chip_addr[15:8]) + $past(st_r.bofs)))
    else $error("chip to buffer mapping wrong");
  auto_capture_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R4]
    f_valid && st_r.auto_mode && !st_r.got_first && !i_file_offset_command
    |=> st_r.fofs == $past(f_page))
    else $error("first page not captured");
  partial_rec_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R8]
    f_valid && i_dl_last && (rec_bad_in || !wr_en)
    |=> $stable(o_dl_loaded_cnt))
    else $error("partial record counted");
  range_drop_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R7]
    f_valid && st_r.got_first && 8'(f_page - st_r.fofs) > 8'h1F |-> !wr_en)
    else $error("out of range byte written");
  prog_invert_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R14]
    st_r.state == BAM_ST_PROG && st_r.op == BAM_OP_PROGRAM && !vpp_bad
    |=> o_chip_wdata == ($past(st_r.inv) ? ~$past(buf_rd) : $past(buf_rd)))
    else $error("write data inversion wrong");
  match_report_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R16]
    o_diff_valid |-> !o_match)
    else $error("match reported after a difference");
endmodule

/* File: logic/bam_pkg.sv */
// Package for the buffer address mapper: constants, commands and states
package bam_pkg;
  // Buffer geometry
  localparam int unsigned BUF_BYTES   = 8192;
  localparam int unsigned PAGE_BITS   = 5;
  localparam int unsigned ADDR_BITS   = 13;
  localparam logic [7:0]  PAGE_LAST   = 8'h1F;
  localparam int unsigned FIFO_DEPTH  = 32;
  localparam int unsigned FIFO_WIDTH  = 24;
  // Reset values
  localparam logic        AUTO_RST    = 1'b1;
  localparam logic [7:0]  FOFS_RST    = 8'h00;
  localparam logic [7:0]  BOFS_RST    = 8'h00;
  localparam logic        INV_RST     = 1'b0;
  // Supply tolerance: 15 percent, in percent steps of the expected level
  localparam int unsigned TOL_PCT     = 15;
  localparam int unsigned TOL_DIV     = 100;
  // Chip operation kinds
  typedef enum logic [1:0] {
    BAM_OP_READ,
    BAM_OP_COMPARE,
    BAM_OP_PROGRAM
  } bam_op_t;
  // Chip operation sequencer states
  typedef enum logic [2:0] {
    BAM_ST_IDLE,
    BAM_ST_ASK,
    BAM_ST_PROG,
    BAM_ST_VERIFY,
    BAM_ST_DONE
  } bam_state_t;
endpackage

/* File: logic/bam_fifo.sv */
// Download byte FIFO, flip-flop storage
`timescale 1ns/1ps
module bam_fifo #(
  parameter int unsigned WIDTH = 24,
  parameter int unsigned DEPTH = 32
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // Fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // Drain side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } bam_fifo_st_t;

  bam_fifo_st_t st_r;
  bam_fifo_st_t st_nxt;
  logic         push;
  logic         pop;

  assign o_in_ready  = (st_r.cnt != (AW+1)'(DEPTH));
  assign o_out_valid = (st_r.cnt != '0);
  assign o_out_data  = st_r.mem[st_r.rp];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_comb
  begin
    st_nxt = st_r;
    if (push)
    begin
      st_nxt.mem[st_r.wp] = i_in_data;
      st_nxt.wp           = st_r.wp + AW'(1);
    end
    if (pop)
    begin
      st_nxt.rp = st_r.rp + AW'(1);
    end
    st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  fifo_no_over_a: assert property (@(posedge i_clk) disable iff (i_rst)
    st_r.cnt == (AW+1)'(DEPTH) |-> !o_in_ready)
    else $error("fifo accepts while full");
endmodule

/* File: test/bam_chip_model.sv */
// Behavioural memory chip in the socket, with its programming supply
`timescale 1ns/1ps
module bam_chip_model (
  // Clock
  input  wire logic               i_clk,
  // Chip bus
  input  wire logic [15:0]        i_addr,
  input  wire logic               i_we,
  input  wire logic [7:0]         i_wdata,
  output logic      [7:0]         o_rdata,
  // Supply
  input  wire logic [9:0]         i_vpp_expect,
  input  wire logic signed [10:0] i_dev,
  output logic      [9:0]         o_vpp_meas
);
  logic [7:0] mem [0:1023];

  initial
  begin
    for (int i = 0; i < 1024; i++)
      mem[i] = 8'(i * 37 + 5);
  end

  // Always selected, so read data always follows the address
  assign o_rdata = mem[i_addr[9:0]];

  always @(posedge i_clk)
  begin
    if (i_we === 1'b1)
      mem[i_addr[9:0]] <= i_wdata;
  end

  assign o_vpp_meas = 10'(int'(i_vpp_expect) + int'(i_dev));
endmodule

/* File: test/bam_top_tb.sv */
// Self-checking bench for the buffer address mapper
`timescale 1ns/1ps
`define CHK(a, b, m) \
  begin \
    comparisons++; \
    if ((a) !== (b)) \
    begin \
      mismatches++; \
      $display("CHECK FAILED at %0t: %s", $time, m); \
    end \
  end
module bam_top_tb;
  import bam_pkg::*;
  // ****************************************
  // Signals and model state
  // ****************************************
  logic i_clk = 0, i_rst = 1;
  logic i_file_offset_command = 0, i_file_offset_auto = 0;
  logic i_buffer_offset_command = 0, i_invert_data_command = 0;
  logic [7:0] i_file_offset = 0, i_buffer_offset = 0;
  logic i_invert_data = 0, i_dl_valid = 0, i_dl_first = 0;
  logic i_dl_last = 0, i_ul_valid = 0, i_op_start = 0;
  logic [15:0] i_dl_addr = 0, i_chip_addr = 0, cur = 0;
  logic [7:0] i_dl_data = 0, i_chip_rdata;
  logic [12:0] i_ul_addr = 0;
  bam_op_t i_op_kind = BAM_OP_READ;
  logic i_chip_step_done = 0, i_op_last = 0;
  logic i_confirm_valid = 0, i_confirm_yes = 0;
  logic [9:0] i_vpp_meas, i_vpp_expect = 10'd500;
  logic signed [10:0] vdev = 0;
  logic o_dl_ready, o_ul_valid, o_chip_we, o_confirm_req;
  logic o_diff_valid, o_match, o_busy, o_abort;
  logic [15:0] o_dl_loaded_cnt, o_ul_addr, o_diff_addr;
  logic [7:0] o_ul_data, o_chip_wdata, dlofs = 0, bofs = 0;
  logic [12:0] o_buf_addr;
  logic [7:0] bm [0:8191];
  bit kn [0:8191];
  bit auto = 1, cap = 1, inv = 0, drop = 0;
  int seed = 83, lcnt = 0, dseen = 0, dexp = 0;
  int mismatches = 0, comparisons = 0;

  bam_top uut (
    .i_clk, .i_rst, .i_file_offset_command, .i_file_offset_auto,
    .i_file_offset, .i_buffer_offset_command, .i_buffer_offset,
    .i_invert_data_command, .i_invert_data, .i_dl_valid, .i_dl_first,
    .i_dl_last, .i_dl_addr, .i_dl_data, .o_dl_ready, .o_dl_loaded_cnt,
    .i_ul_valid, .i_ul_addr, .o_ul_valid, .o_ul_addr, .o_ul_data,
    .i_op_start, .i_op_kind, .i_chip_addr, .i_chip_rdata, .o_chip_wdata,
    .o_chip_we, .i_chip_step_done, .i_op_last, .o_buf_addr,
    .o_confirm_req, .i_confirm_valid, .i_confirm_yes, .o_diff_valid,
    .o_diff_addr, .o_match, .o_busy, .i_vpp_meas, .i_vpp_expect, .o_abort
  );
  bam_chip_model chip (
    .i_clk, .i_addr(i_chip_addr), .i_we(o_chip_we),
    .i_wdata(o_chip_wdata), .o_rdata(i_chip_rdata),
    .i_vpp_expect, .i_dev(vdev), .o_vpp_meas(i_vpp_meas)
  );

  always #10 i_clk = ~i_clk;

  always @(posedge i_clk)
    if (o_diff_valid === 1'b1)
    begin
      dseen++;
      `CHK(o_diff_addr, cur, "diff address")
    end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic stuck(input string m);
    mismatches++;
    $display("CHECK FAILED at %0t: %s", $time, m);
    give_verdict();
  endtask

  // One byte at a time keeps first/last aligned with the FIFO head
  task automatic dl(input bit f, input bit l, input logic [15:0] a);
    int k;
    logic [7:0] d;
    logic [7:0] p;
    d = 8'($random(seed));
    i_dl_valid <= 1'b1;
    i_dl_first <= f;
    i_dl_last <= l;
    i_dl_addr <= a;
    i_dl_data <= d;
    #1;
    for (k = 0; k < 20 && o_dl_ready !== 1'b1; k++)
      @(negedge i_clk);
    if (k == 20) stuck("download stall");
    tick(1);
    i_dl_valid <= 1'b0;
    tick(4);
    if (f) drop = 0;
    if (cap) dlofs = a[15:8];
    cap = 0;
    p = a[15:8] - dlofs;
    if (p <= 8'h1F) bm[{p[4:0], a[7:0]}] = d;
    if (p <= 8'h1F) kn[{p[4:0], a[7:0]}] = 1;
    else drop = 1;
    if (l && !drop) lcnt++;
  endtask

  task automatic rec(input logic [15:0] a, input int n);
    for (int i = 0; i < n; i++)
      dl(i == 0, i == n - 1, a + 16'(i));
    `CHK(o_dl_loaded_cnt, 16'(lcnt), "loaded records")
  endtask

  task automatic ul_all();
    logic [7:0] hi;
    for (int a = 0; a < 8192; a++)
      if (kn[a])
      begin
        tick(1);
        i_ul_valid <= 1'b1;
        i_ul_addr <= 13'(a);
        tick(1);
        i_ul_valid <= 1'b0;
        #1;
        hi = 8'(a >> 8) + (auto ? 8'h00 : dlofs);
        `CHK(o_ul_valid, 1'b1, "upload valid")
        `CHK(o_ul_addr, {hi, 8'(a)}, "upload address")
        `CHK(o_ul_data, bm[a], "upload data")
      end
  endtask

  task automatic file_offset_command(input bit au, input logic [7:0] v);
    tick(1);
    i_file_offset_command <= 1'b1;
    i_file_offset_auto <= au;
    i_file_offset <= v;
    tick(1);
    i_file_offset_command <= 1'b0;
    auto = au;
    cap = au;
    if (!au) dlofs = v;
  endtask

  task automatic cfg(input logic [7:0] bo, input bit iv);
    tick(1);
    i_buffer_offset_command <= 1'b1;
    i_buffer_offset <= bo;
    i_invert_data_command <= 1'b1;
    i_invert_data <= iv;
    tick(1);
    i_buffer_offset_command <= 1'b0;
    i_invert_data_command <= 1'b0;
    bofs = bo;
    inv = iv;
  endtask

  // Mode 0 program, 1 verify, 2 read into buffer
  task automatic step(input logic [15:0] a, input bit last, input int md);
    logic [12:0] b;
    tick(1);
    cur = a;
    i_chip_addr <= a;
    b = {a[12:8] + bofs[4:0], a[7:0]};
    if (md == 2) bm[b] = chip.mem[a[9:0]] ^ {8{inv}};
    if (md == 2) kn[b] = 1;
    if (md == 1 && (chip.mem[a[9:0]] ^ {8{inv}}) !== bm[b]) dexp++;
    tick(3);
    i_chip_step_done <= 1'b1;
    i_op_last <= last;
    tick(1);
    i_chip_step_done <= 1'b0;
    i_op_last <= 1'b0;
    tick(2);
    `CHK(o_buf_addr, b, "buffer address")
  endtask

  task automatic op(input bam_op_t kd, input logic [15:0] base,
                    input int n, input bit yes);
    int k;
    dseen = 0;
    dexp = 0;
    tick(1);
    i_op_kind <= kd;
    i_op_start <= 1'b1;
    tick(1);
    i_op_start <= 1'b0;
    if (kd == BAM_OP_PROGRAM)
    begin
      for (k = 0; k < 20 && o_confirm_req !== 1'b1; k++)
        @(negedge i_clk);
      `CHK(o_confirm_req, 1'b1, "confirmation asked")
      `CHK(o_busy, 1'b1, "busy while asking")
      tick(1);
      i_confirm_valid <= 1'b1;
      i_confirm_yes <= yes;
      tick(1);
      i_confirm_valid <= 1'b0;
    end
    if (kd != BAM_OP_PROGRAM || yes)
      for (int ph = 0; ph < ((kd == BAM_OP_PROGRAM) ? 2 : 1); ph++)
        for (int i = 0; i < n; i++)
          step(base + 16'(i), i == n - 1, (kd == BAM_OP_READ) ? 2 :
               (kd == BAM_OP_COMPARE || ph == 1) ? 1 : 0);
    for (k = 0; k < 50 && o_busy !== 1'b0; k++)
      @(negedge i_clk);
    if (k == 50) stuck("operation never ends");
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    int dv [4] = '{75, -75, 76, -76};
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    @(negedge i_clk);
    `CHK(o_busy, 1'b0, "idle after reset")
    `CHK(o_abort, 1'b0, "no abort after reset")
    rec(16'h40F0, 4);
    rec(16'h41FE, 4);
    rec(16'h3FFE, 4);
    rec(16'h5FFE, 4);
    ul_all();
    $display("done: automatic offset download");
    file_offset_command(0, 8'h10);
    rec(16'h1000, 2);
    rec(16'h0F00, 2);
    ul_all();
    $display("done: explicit offset transfer");
    // Page 02 plus offset 1E wraps to page 00
    cfg(8'h1E, 1);
    op(BAM_OP_READ, 16'h01FE, 4, 1);
    ul_all();
    cfg(8'h1E, 0);
    op(BAM_OP_COMPARE, 16'h01FE, 4, 1);
    `CHK(dseen, 4, "every byte differs")
    `CHK(o_match, 1'b0, "no match reported")
    cfg(8'h1E, 1);
    op(BAM_OP_COMPARE, 16'h01FE, 4, 1);
    `CHK(dseen, dexp, "difference count")
    `CHK(o_match, 1'b1, "match reported")
    $display("done: read and compare");
    cfg(8'h00, 1);
    op(BAM_OP_PROGRAM, 16'h00F0, 4, 0);
    for (int i = 0; i < 4; i++)
      `CHK(chip.mem[240 + i], 8'((240 + i) * 37 + 5), "declined")
    op(BAM_OP_PROGRAM, 16'h00F0, 4, 1);
    for (int i = 0; i < 4; i++)
      `CHK(chip.mem[240 + i], ~bm[240 + i], "programmed data")
    `CHK(dseen, 0, "verify clean")
    `CHK(o_match, 1'b1, "verify match")
    $display("done: program");
    foreach (dv[j])
    begin
      tick(1);
      vdev <= 11'(dv[j]);
      op(BAM_OP_PROGRAM, 16'h00F0, 2, 1);
      `CHK(o_abort, (dv[j] * dv[j] * 100 > 75 * 75 * 100), "abort")
      tick(1);
      vdev <= 11'sd0;
    end
    $display("done: supply monitor");
    give_verdict();
  end

  initial
  begin
    #2000000;
    stuck("run timeout");
  end
endmodule
